//--- shared/eec_consts.svh
// eeprom command control: register offsets, field positions, op codes, timing
// assumes a 12-bit byte address on the register bus and a 10 MHz clock
`ifndef EEC_CONSTS_SVH
`define EEC_CONSTS_SVH

// register byte offsets
`define EEC_OFS_CMD 12'h1b4
`define EEC_OFS_DATA 12'h1b8
`define EEC_OFS_IRQ_STS 12'h1c0
`define EEC_OFS_IRQ_MSK 12'h1c4

// eeprom_command field positions
`define EEC_BUSY_BIT 31
`define EEC_OP_HI 30
`define EEC_OP_LO 28
`define EEC_TO_BIT 17
`define EEC_LOADED_BIT 16
`define EEC_ADDR_HI 15
`define EEC_ADDR_LO 0

// operation_select encodings and reset value
`define EEC_OP_READ 3'h0
`define EEC_OP_WRITE 3'h3
`define EEC_OP_RELOAD 3'h7
`define EEC_OP_RST 3'h0

// interrupt status / mask bit positions
`define EEC_IRQ_DONE 0
`define EEC_IRQ_TO 1

// timing: access timeout
`define EEC_CLK_PERIOD_NS 100
`define EEC_TIMEOUT_NS 30000
`define EEC_TIMEOUT_CYC (`EEC_TIMEOUT_NS / `EEC_CLK_PERIOD_NS)

`endif

//--- shared/eec_pkg.sv
// eeprom command control: shared types
// assumes nothing beyond the constants header
package eec_pkg;

  // engine states
  typedef enum logic [1:0] {
    EEC_ST_IDLE = 2'b00,
    EEC_ST_ACCESS = 2'b01,
    EEC_ST_LOAD = 2'b10,
    EEC_ST_RSV = 2'b11
  } eec_state_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eec_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eec_apb_rsp_t;

  // request to the two-wire eeprom engine
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } eec_acc_req_t;

  // answer from the two-wire eeprom engine
  typedef struct packed {
    logic done;
    logic nack;
    logic [7:0] rdata;
  } eec_acc_rsp_t;

  // timeout counter state
  typedef struct packed {
    logic [15:0] cnt;
    logic expired;
  } eec_tmr_st_t;

  // top level state
  typedef struct packed {
    eec_state_t state;
    logic busy;
    logic [2:0] op;
    logic [15:0] addr;
    logic loaded;
    logic to_flag;
    logic [7:0] data;
    logic [1:0] sts;
    logic [1:0] msk;
    logic irq;
    logic reload;
    eec_apb_rsp_t apb;
    eec_acc_req_t acc;
  } eec_top_st_t;

endpackage

//--- rtl/eec_tmr.sv
// eeprom command control: access timeout counter
// assumes run_i is high for the whole of one outstanding access
`timescale 1ns/10ps
module eec_tmr
  import eec_pkg::*;
#(
  parameter int CYC = 300
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control and result
  input wire logic run_i,
  output logic expired_o
);

  eec_tmr_st_t r_ff;
  eec_tmr_st_t nxt_r;

  // refuse counts the 16-bit counter cannot hold
  if (CYC < 1 || CYC > 65535) begin : g_chk
    $error("eec_tmr: CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // count while running, flag once the limit is reached, clear when idle
  always_comb begin
    nxt_r = r_ff;
    if (!run_i) begin
      nxt_r.cnt = 16'h0000;
      nxt_r.expired = 1'b0;
    end else if (r_ff.cnt == 16'(CYC - 1)) begin
      nxt_r.expired = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  assign expired_o = r_ff.expired;

endmodule

//--- rtl/eec_top.sv
// eeprom command control: apb register block and command engine
// assumes a two-wire eeprom engine on the acc ports and a config loader
// that reports completion on cfg_load_done_i
`timescale 1ns/10ps
`include "eec_consts.svh"

// Summary of operation
// - Writing one to busy bit 31 starts the selected operation at the programmed address.
// - Busy stays set for the whole operation and clears itself when it ends.
// - After a read, busy clearing means the data register holds the fetched byte.
// - A write with no eeprom keeps busy set until the timeout flag sets, then clears.
// - Busy is forced set after power-up, pin reset and digital reset.
// - After any reset busy clears only once the configuration loader is done.
// - A 3-bit operation field at 30:28 resets to zero; 0 reads, 1 is reserved.
module eec_top
  import eec_pkg::*;
#(
  parameter int TIMEOUT_CYC = `EEC_TIMEOUT_CYC
) (
  // clock, resets, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic digital_rst_i,
  input wire logic ce_i,
  // apb slave
  input wire eec_apb_req_t apb_i,
  output eec_apb_rsp_t apb_o,
  // eeprom engine
  output eec_acc_req_t acc_o,
  input wire eec_acc_rsp_t acc_i,
  // configuration loader
  output logic reload_o,
  input wire logic cfg_load_done_i,
  // interrupt
  output logic irq_o
);

  // reset value of the whole state
  localparam eec_top_st_t RST_ST = '{
    state: EEC_ST_LOAD,
    busy: 1'b1,
    op: `EEC_OP_RST,
    default: '0
  };

  eec_top_st_t r_ff;
  eec_top_st_t nxt_r;
  logic any_rst;
  logic tmr_expired;
  logic setup;
  logic wr_acc;
  logic start;
  logic ev_done;
  logic ev_to;
  logic [31:0] cmd_rd;

  // refuse timeouts the counter cannot serve
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_chk
    $error("eec_top: TIMEOUT_CYC out of range");
  end

  // pin and software digital reset act alike
  assign any_rst = rst_i | digital_rst_i;

  ////////////////////////////////////////////////////////////////////////////
  // timeout for the outstanding eeprom access
  eec_tmr #(
    .CYC(TIMEOUT_CYC)
  ) u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_i(any_rst),
    .ce_i(ce_i),
    .run_i(r_ff.state == EEC_ST_ACCESS),
    .expired_o(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read view of the command register
  always_comb begin
    cmd_rd = 32'h0000_0000;
    cmd_rd[`EEC_BUSY_BIT] = r_ff.busy;
    cmd_rd[`EEC_OP_HI:`EEC_OP_LO] = r_ff.op;
    cmd_rd[`EEC_TO_BIT] = r_ff.to_flag;
    cmd_rd[`EEC_LOADED_BIT] = r_ff.loaded;
    cmd_rd[`EEC_ADDR_HI:`EEC_ADDR_LO] = r_ff.addr;
  end

  // apb phase decode
  assign setup = apb_i.psel && !apb_i.penable;
  assign wr_acc = apb_i.psel && apb_i.penable && r_ff.apb.pready && apb_i.pwrite;
  // a command launch is only honoured while idle
  assign start = wr_acc && (apb_i.paddr == `EEC_OFS_CMD) && apb_i.pwdata[`EEC_BUSY_BIT]
                 && !r_ff.busy;

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, then command engine, then interrupt
  always_comb begin
    nxt_r = r_ff;
    ev_done = 1'b0;
    ev_to = 1'b0;
    nxt_r.apb.pready = 1'b0;
    nxt_r.apb.pslverr = 1'b0;
    nxt_r.reload = 1'b0;

    // setup cycle: prepare the answer for a zero-wait access phase
    if (setup) begin
      nxt_r.apb.pready = 1'b1;
      case (apb_i.paddr)
        `EEC_OFS_CMD: nxt_r.apb.prdata = cmd_rd;
        `EEC_OFS_DATA: nxt_r.apb.prdata = {24'h00_0000, r_ff.data};
        `EEC_OFS_IRQ_STS: nxt_r.apb.prdata = {30'h0000_0000, r_ff.sts};
        `EEC_OFS_IRQ_MSK: nxt_r.apb.prdata = {30'h0000_0000, r_ff.msk};
        default: begin
          nxt_r.apb.prdata = 32'h0000_0000;
          nxt_r.apb.pslverr = 1'b1;
        end
      endcase
    end

    // register writes take effect in the access phase
    if (wr_acc) begin
      case (apb_i.paddr)
        `EEC_OFS_CMD: begin
          // fields are frozen while an operation runs
          if (!r_ff.busy) begin
            nxt_r.op = apb_i.pwdata[`EEC_OP_HI:`EEC_OP_LO];
            nxt_r.addr = apb_i.pwdata[`EEC_ADDR_HI:`EEC_ADDR_LO];
          end
          // timeout flag is write-one-to-clear
          if (apb_i.pwdata[`EEC_TO_BIT]) begin
            nxt_r.to_flag = 1'b0;
          end
        end
        `EEC_OFS_DATA: begin
          if (!r_ff.busy) begin
            nxt_r.data = apb_i.pwdata[7:0];
          end
        end
        `EEC_OFS_IRQ_STS: nxt_r.sts = r_ff.sts & ~apb_i.pwdata[1:0];
        `EEC_OFS_IRQ_MSK: nxt_r.msk = apb_i.pwdata[1:0];
        default: begin
        end
      endcase
    end

    // command engine
    case (r_ff.state)
      EEC_ST_IDLE: begin
        if (start) begin
          nxt_r.busy = 1'b1;
          case (apb_i.pwdata[`EEC_OP_HI:`EEC_OP_LO])
            `EEC_OP_READ: begin
              nxt_r.acc.req = 1'b1;
              nxt_r.acc.write = 1'b0;
              nxt_r.acc.addr = apb_i.pwdata[`EEC_ADDR_HI:`EEC_ADDR_LO];
              nxt_r.state = EEC_ST_ACCESS;
            end
            `EEC_OP_WRITE: begin
              nxt_r.acc.req = 1'b1;
              nxt_r.acc.write = 1'b1;
              nxt_r.acc.addr = apb_i.pwdata[`EEC_ADDR_HI:`EEC_ADDR_LO];
              nxt_r.acc.wdata = r_ff.data;
              nxt_r.state = EEC_ST_ACCESS;
            end
            `EEC_OP_RELOAD: begin
              nxt_r.reload = 1'b1;
              nxt_r.loaded = 1'b0;
              nxt_r.state = EEC_ST_LOAD;
            end
            default: nxt_r.state = EEC_ST_RSV;
          endcase
        end
      end
      EEC_ST_ACCESS: begin
        // busy holds until the engine answers or the timer runs out
        if (acc_i.nack || tmr_expired) begin
          nxt_r.acc.req = 1'b0;
          nxt_r.busy = 1'b0;
          ev_to = 1'b1;
          nxt_r.state = EEC_ST_IDLE;
        end else if (acc_i.done) begin
          nxt_r.acc.req = 1'b0;
          nxt_r.busy = 1'b0;
          if (!r_ff.acc.write) begin
            nxt_r.data = acc_i.rdata;
          end
          ev_done = 1'b1;
          nxt_r.state = EEC_ST_IDLE;
        end
      end
      EEC_ST_LOAD: begin
        // busy is released only by the loader
        if (cfg_load_done_i) begin
          nxt_r.busy = 1'b0;
          nxt_r.loaded = 1'b1;
          nxt_r.state = EEC_ST_IDLE;
        end
      end
      EEC_ST_RSV: begin
        // reserved code: no bus traffic, finish at once
        nxt_r.busy = 1'b0;
        ev_done = 1'b1;
        nxt_r.state = EEC_ST_IDLE;
      end
      default: nxt_r.state = EEC_ST_IDLE;
    endcase

    // sticky flags: a new event wins over a clear in the same cycle
    if (ev_to) begin
      nxt_r.to_flag = 1'b1;
      nxt_r.sts[`EEC_IRQ_TO] = 1'b1;
    end
    if (ev_done) begin
      nxt_r.sts[`EEC_IRQ_DONE] = 1'b1;
    end
    nxt_r.irq = |(nxt_r.sts & nxt_r.msk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register: every reset forces busy and waits for the loader
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      r_ff <= RST_ST;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from the state register
  assign apb_o = r_ff.apb;
  assign acc_o = r_ff.acc;
  assign reload_o = r_ff.reload;
  assign irq_o = r_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a read launch drives a read request at the written address next cycle
  AST_START_READ: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (ce_i && start && apb_i.pwdata[`EEC_OP_HI:`EEC_OP_LO] == `EEC_OP_READ)
    |=> (r_ff.busy && acc_o.req && !acc_o.write
         && acc_o.addr == $past(apb_i.pwdata[`EEC_ADDR_HI:`EEC_ADDR_LO])))
    else $error("read launch did not raise a read request");

  // busy holds while the engine has not answered
  AST_BUSY_HOLD: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (r_ff.state == EEC_ST_ACCESS && !(ce_i && (acc_i.done || acc_i.nack || tmr_expired)))
    |=> (r_ff.busy && acc_o.req))
    else $error("busy dropped during an access");

  // read completion clears busy and captures the byte in the same edge
  AST_READ_DATA: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (ce_i && r_ff.state == EEC_ST_ACCESS && !acc_o.write && acc_i.done
     && !acc_i.nack && !tmr_expired)
    |=> (!r_ff.busy && r_ff.data == $past(acc_i.rdata) && !acc_o.req))
    else $error("read completion did not deliver data");

  // no answer: timeout flag and busy clear land together
  AST_TIMEOUT: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (ce_i && r_ff.state == EEC_ST_ACCESS && (acc_i.nack || tmr_expired))
    |=> (!r_ff.busy && r_ff.to_flag && r_ff.sts[`EEC_IRQ_TO]))
    else $error("timeout did not set the flag and clear busy");

  // any reset leaves busy set and waits for the loader
  AST_RST_BUSY: assert property (@(posedge ref_clk_i)
    any_rst |=> (r_ff.busy && r_ff.state == EEC_ST_LOAD && !acc_o.req))
    else $error("busy not forced after reset");

  // loader wait: busy held until the loader reports done, then clears
  AST_LOAD_WAIT: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (r_ff.state == EEC_ST_LOAD)
    |=> (r_ff.busy == !$past(ce_i && cfg_load_done_i)))
    else $error("busy released out of step with the loader");

  // operation field reads back zero after reset
  AST_OP_RESET: assert property (@(posedge ref_clk_i)
    any_rst |=> (r_ff.op == `EEC_OP_RST && cmd_rd[`EEC_OP_HI:`EEC_OP_LO] == 3'h0))
    else $error("operation field not zero after reset");

  // reserved code: one busy cycle, no bus request, then idle
  AST_RSV_CODE: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (ce_i && start && apb_i.pwdata[`EEC_OP_HI:`EEC_OP_LO] == 3'h1) ##1 ce_i
    |=> (!r_ff.busy && !acc_o.req && r_ff.sts[`EEC_IRQ_DONE]))
    else $error("reserved code did not complete quietly");

  // a reload launch pulses the loader request and waits in the load state
  AST_RELOAD_START: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (ce_i && start && apb_i.pwdata[`EEC_OP_HI:`EEC_OP_LO] == `EEC_OP_RELOAD)
    |=> (reload_o && r_ff.busy && r_ff.state == EEC_ST_LOAD && !acc_o.req))
    else $error("reload launch did not reach the loader");

  // every setup cycle is answered with zero wait states, and only those
  AST_APB_READY: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    ce_i |=> (apb_o.pready == $past(setup)))
    else $error("bus answer out of step with the setup cycle");

  // the done status holds until software writes a one to it
  AST_STS_STICKY: assert property (@(posedge ref_clk_i) disable iff (any_rst)
    (r_ff.sts[`EEC_IRQ_DONE] && !(ce_i && wr_acc && apb_i.paddr == `EEC_OFS_IRQ_STS
     && apb_i.pwdata[`EEC_IRQ_DONE]))
    |=> r_ff.sts[`EEC_IRQ_DONE])
    else $error("done status dropped without a clear");

endmodule

//--- testbench/eec_eeprom_model.sv
// eeprom engine model: answers access requests after delay_i cycles
// assumes the engine port of eec_top; absent_i models a missing device
`timescale 1ns/10ps
module eec_eeprom_model
  import eec_pkg::*;
(
  // clock, reset, behaviour
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic absent_i,
  input wire logic [3:0] delay_i,
  // engine port
  input wire eec_acc_req_t acc_i,
  output eec_acc_rsp_t acc_o
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_ff = 4'h0;

  initial acc_o = '0;

  ////////////////////////////////////////////////////////////////
  // one-cycle done after the delay; rdata churns while not valid
  always @(posedge ref_clk_i) begin
    acc_o.done <= 1'b0;
    acc_o.nack <= 1'b0;
    acc_o.rdata <= acc_o.rdata + 8'h3b;
    if (rst_i || !acc_i.req || acc_o.done) begin
      wait_ff <= 4'h0;
      if (rst_i) begin
        for (int i = 0; i < 256; i++) begin
          mem[i] <= i[7:0] ^ 8'ha5;
        end
      end
    end else if (!absent_i && wait_ff == delay_i) begin
      acc_o.done <= 1'b1;
      acc_o.rdata <= mem[acc_i.addr[7:0]];
      if (acc_i.write) begin
        mem[acc_i.addr[7:0]] <= acc_i.wdata;
      end
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

//--- testbench/eec_top_tb.sv
// testbench for eec_top: apb master, eeprom model, loader handshake
// assumes the register map of eec_consts.svh and a shortened timeout
`timescale 1ns/10ps
`include "eec_consts.svh"
module eec_top_tb
  import eec_pkg::*;
;
  localparam int TO_CYC = 30;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dig_rst = 1'b0;
  logic load_done = 1'b0;
  logic absent = 1'b0;
  logic ce = 1'b1;
  eec_apb_req_t apb_req = '0;
  eec_apb_rsp_t apb_rsp;
  eec_acc_req_t acc_req;
  eec_acc_rsp_t acc_rsp;
  logic reload;
  logic irq;
  logic req_q = 1'b0;
  logic seen_wr = 1'b0;
  logic [15:0] seen_addr = 16'h0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int compares = 0;
  int req_rises = 0;
  int reloads = 0;

  eec_top #(.TIMEOUT_CYC(TO_CYC)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .digital_rst_i(dig_rst), .ce_i(ce),
    .apb_i(apb_req), .apb_o(apb_rsp), .acc_o(acc_req), .acc_i(acc_rsp),
    .reload_o(reload), .cfg_load_done_i(load_done), .irq_o(irq)
  );
  eec_eeprom_model i_mem (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .absent_i(absent), .delay_i(4'ha),
    .acc_i(acc_req), .acc_o(acc_rsp)
  );

  always #50 ref_clk_i = ~ref_clk_i;

  // note each new access request and each reload pulse
  always @(posedge ref_clk_i) begin
    req_q <= acc_req.req;
    if (acc_req.req === 1'b1 && req_q !== 1'b1) begin
      req_rises <= req_rises + 1;
      seen_addr <= acc_req.addr;
      seen_wr <= acc_req.write;
    end
    if (reload === 1'b1) reloads <= reloads + 1;
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk_i);
    apb_req.penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge ref_clk_i);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    check("slave error", {31'h0, err}, {31'h0, !(a inside {`EEC_OFS_CMD, `EEC_OFS_DATA,
          `EEC_OFS_IRQ_STS, `EEC_OFS_IRQ_MSK})});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // poll busy with a bounded count before the next command
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, `EEC_OFS_CMD, 32'h0);
      n++;
    end while (rd[31] !== 1'b0 && n < 60);
    check("busy clears", {31'h0, rd[31]}, 32'h0);
  endtask

  task automatic load_pulse();
    @(posedge ref_clk_i);
    load_done <= 1'b1;
    @(posedge ref_clk_i);
    load_done <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("command after reset", rd, 32'h8000_0000);
    wr(`EEC_OFS_CMD, 32'h8000_0012);
    repeat (3) @(posedge ref_clk_i);
    check("start while loading", 32'(req_rises), 32'h0);
    load_pulse();
    wait_idle();
    check("ignored while busy", rd & 32'h8000_ffff, 32'h0);
    dig_rst <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    dig_rst <= 1'b0;
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("busy after digital reset", {31'h0, rd[31]}, 32'h1);
    load_pulse();
    wait_idle();
  endtask

  task automatic t_read(input logic [15:0] a, input logic [7:0] exp);
    wr(`EEC_OFS_IRQ_MSK, 32'h1);
    wr(`EEC_OFS_CMD, {1'b1, `EEC_OP_READ, 12'h0, a});
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("busy during read", {31'h0, rd[31]}, 32'h1);
    wait_idle();
    check("access address", {16'h0, seen_addr}, {16'h0, a});
    check("access direction", {31'h0, seen_wr}, 32'h0);
    apb(1'b0, `EEC_OFS_DATA, 32'h0);
    check("read data", rd, {24'h0, exp});
    check("done irq", {31'h0, irq}, 32'h1);
    wr(`EEC_OFS_IRQ_STS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    check("irq after clear", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_write();
    wr(`EEC_OFS_IRQ_MSK, 32'h0);
    wr(`EEC_OFS_DATA, 32'h5c);
    wr(`EEC_OFS_CMD, {1'b1, `EEC_OP_WRITE, 12'h0, 16'h0040});
    wait_idle();
    check("write direction", {31'h0, seen_wr}, 32'h1);
    check("masked irq", {31'h0, irq}, 32'h0);
    t_read(16'h0040, 8'h5c);
  endtask

  task automatic t_timeout();
    absent <= 1'b1;
    wr(`EEC_OFS_CMD, {1'b1, `EEC_OP_WRITE, 12'h0, 16'h0041});
    repeat (TO_CYC - 4) @(posedge ref_clk_i);
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("busy before timeout", {30'h0, rd[31], rd[17]}, 32'h2);
    wait_idle();
    check("timeout flag", {31'h0, rd[17]}, 32'h1);
    apb(1'b0, `EEC_OFS_IRQ_STS, 32'h0);
    check("timeout status", rd, 32'h2);
    wr(`EEC_OFS_IRQ_STS, 32'h3);
    wr(`EEC_OFS_CMD, 32'h0002_0000);
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("timeout flag cleared", {31'h0, rd[17]}, 32'h0);
    absent <= 1'b0;
  endtask

  task automatic t_reserved();
    logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int base;
    base = req_rises;
    foreach (codes[i]) begin
      wr(`EEC_OFS_CMD, {1'b1, codes[i], 28'h55});
      wait_idle();
      check("op field", {29'h0, rd[30:28]}, {29'h0, codes[i]});
      apb(1'b0, `EEC_OFS_IRQ_STS, 32'h0);
      check("reserved done", rd, 32'h1);
      wr(`EEC_OFS_IRQ_STS, 32'h1);
    end
    check("reserved bus requests", 32'(req_rises - base), 32'h0);
  endtask

  task automatic t_reload();
    int base;
    base = reloads;
    wr(`EEC_OFS_CMD, {1'b1, `EEC_OP_RELOAD, 28'h0});
    repeat (4) @(posedge ref_clk_i);
    check("reload pulses", 32'(reloads - base), 32'h1);
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("busy during reload", {31'h0, rd[31]}, 32'h1);
    // a loader report while the clock enable is low must be ignored
    ce <= 1'b0;
    load_pulse();
    ce <= 1'b1;
    apb(1'b0, `EEC_OFS_CMD, 32'h0);
    check("busy while frozen", {31'h0, rd[31]}, 32'h1);
    load_pulse();
    wait_idle();
    apb(1'b0, 12'h1d0, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic print_verdict();
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_read(16'h0012, 8'h12 ^ 8'ha5);
    t_write();
    t_timeout();
    t_reserved();
    t_reload();
    print_verdict();
  end

  // watchdog: the run needs a few hundred cycles, allow 20000
  initial begin
    #2000000;
    fail_count++;
    print_verdict();
  end
endmodule
